// file: rs_ecc_pkg.sv
// Constants, register map and types for the NAND Reed-Solomon ECC control block
`default_nettype none
package rs_ecc_pkg;
  // Register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h68;
  localparam logic [7:0] OFF_RPAR1 = 8'h6c;
  localparam logic [7:0] OFF_RPAR2 = 8'h70;
  localparam logic [7:0] OFF_RPAR3 = 8'h74;
  localparam logic [7:0] OFF_WPAR1 = 8'h78;
  localparam logic [7:0] OFF_WPAR2 = 8'h7c;
  localparam logic [7:0] OFF_WPAR3 = 8'h80;
  localparam logic [7:0] OFF_STAT = 8'h84;
  localparam logic [7:0] OFF_IRQ_ST = 8'h88;
  localparam logic [7:0] OFF_IRQ_EN = 8'h8c;
  localparam logic [7:0] OFF_IRQ_CLR = 8'h90;
  // Control field positions
  localparam int BIT_ENGINE_ON = 0;
  localparam int BIT_RELOAD_KICK = 1;
  localparam int BIT_PRECOMP_KICK = 2;
  // Interrupt status bits
  localparam int IRQ_PRECOMP_DONE = 0;
  localparam int IRQ_RELOAD_DONE = 1;
  localparam int IRQ_READ_DONE = 2;
  localparam int IRQ_W = 3;
  // Reset values
  localparam logic RST_ENGINE_ON = 1'b0;
  localparam logic [71:0] RST_PARITY = 72'h0;
  localparam logic [1:0] RST_ERR_CODE = 2'h0;
  // Block geometry
  localparam int BLOCK_BYTES = 512;
  localparam int PARITY_BYTES = 9;
  localparam logic [9:0] BLOCK_LAST = 10'h1ff;
  localparam logic [9:0] BLOCK_END = 10'h200;
  // Field polynomial and generator coefficients (plain defaults)
  localparam logic [7:0] GF_POLY = 8'h1d;
  localparam logic [7:0] RS_GEN_COEF [0:8] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h10, 8'h20, 8'h40, 8'h80, 8'h1d};

  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b00,
    SEQ_PRECOMP = 2'b01,
    SEQ_LATCH = 2'b10,
    SEQ_RELOAD = 2'b11
  } seq_state_t;

  // Multiply two field elements
  function automatic logic [7:0] gf_mul(input logic [7:0] a, input logic [7:0] b);
    logic [7:0] acc;
    logic [7:0] sh;
    acc = 8'h00;
    sh = a;
    for (int i = 0; i < 8; i++)
    begin
      if (b[i])
        acc = acc ^ sh;
      sh = sh[7] ? ({sh[6:0], 1'b0} ^ GF_POLY) : {sh[6:0], 1'b0};
    end
    return acc;
  endfunction : gf_mul
endpackage : rs_ecc_pkg
`default_nettype wire

// file: ecc_engine_if.sv
// Carrier between the control sequencer and the parity/buffer engine
`default_nettype none
interface ecc_engine_if;
  logic enc_clear;
  logic enc_shift;
  logic [7:0] enc_byte;
  logic [71:0] parity;
  logic cap_valid;
  logic [7:0] cap_byte;
  logic cap_restart;
  logic fix_valid;
  logic [8:0] fix_addr;
  logic [7:0] fix_xor;
  logic [8:0] rd_idx;
  logic [7:0] rd_byte;
  modport ctrl (output enc_clear, enc_shift, enc_byte, cap_valid, cap_byte, cap_restart,
                output fix_valid, fix_addr, fix_xor, rd_idx, input parity, rd_byte);
  modport eng (input enc_clear, enc_shift, enc_byte, cap_valid, cap_byte, cap_restart,
               input fix_valid, fix_addr, fix_xor, rd_idx, output parity, rd_byte);
endinterface : ecc_engine_if
`default_nettype wire

// file: rs_ecc_engine.sv
// Parity encoder and read-block buffer with in-place correction
`default_nettype none
module rs_ecc_engine
  import rs_ecc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  ecc_engine_if.eng eif
);
  logic [7:0] blk_mem [0:BLOCK_BYTES-1];
  logic [71:0] par_ff;
  logic [71:0] nxt_par;
  logic [8:0] cap_idx_ff;
  logic [8:0] nxt_cap_idx;
  logic [7:0] fb;

  // Feedback byte of the systematic encoder
  assign fb = eif.enc_byte ^ par_ff[71:64];

  // One stage per parity byte
  genvar g;
  generate
    for (g = 0; g < PARITY_BYTES; g++)
    begin : g_stage
      always_comb
      begin
        if (eif.enc_clear)
          nxt_par[g*8 +: 8] = 8'h00;
        else if (eif.enc_shift)
          nxt_par[g*8 +: 8] = ((g == 0) ? 8'h00 : par_ff[(g == 0 ? 0 : g*8-8) +: 8]) ^ gf_mul(fb, RS_GEN_COEF[g]);
        else
          nxt_par[g*8 +: 8] = par_ff[g*8 +: 8];
      end
    end
  endgenerate

  // Capture index restarts with each block so a fresh read never mixes with the last
  always_comb
  begin
    nxt_cap_idx = cap_idx_ff;
    if (eif.cap_restart)
      nxt_cap_idx = 9'h000;
    else if (eif.cap_valid)
      nxt_cap_idx = cap_idx_ff + 9'h001;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      par_ff <= RST_PARITY;
      cap_idx_ff <= 9'h000;
    end
    else if (ce)
    begin
      par_ff <= nxt_par;
      cap_idx_ff <= nxt_cap_idx;
    end
  end

  // Buffer is not reset; a correction patches the byte at fix_addr, and a same-cycle capture takes priority
  always_ff @(posedge clk)
  begin
    if (ce && eif.cap_valid && !eif.cap_restart)
      blk_mem[cap_idx_ff] <= eif.cap_byte;
    else if (ce && eif.fix_valid)
      blk_mem[eif.fix_addr] <= blk_mem[eif.fix_addr] ^ eif.fix_xor;
  end

  assign eif.parity = par_ff;
  assign eif.rd_byte = blk_mem[eif.rd_idx];
endmodule : rs_ecc_engine
`default_nettype wire

// file: nand_rs_ecc_ctrl.sv
// Top of the Reed-Solomon ECC control block: register slave, kick sequencer, interrupts
`default_nettype none
module nand_rs_ecc_ctrl
  import rs_ecc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [7:0] tx_data,
  input wire logic tx_valid,
  output logic tx_ready,
  output logic flash_tx_hold,
  input wire logic [7:0] rd_data,
  input wire logic rd_valid,
  input wire logic dec_done,
  input wire logic [1:0] dec_code,
  input wire logic fix_valid,
  input wire logic [8:0] fix_addr,
  input wire logic [7:0] fix_xor,
  output logic [71:0] read_parity,
  output logic reed_solomon_engine_on,
  output logic [7:0] rx_data,
  output logic rx_valid,
  input wire logic rx_ready,
  output logic irq
);
  import rs_ecc_pkg::*;

  ecc_engine_if eif ();

  logic rst_sync1_ff;
  logic rst_sync2_ff;
  logic srst_n;
  logic wait_ff;
  logic nxt_wait;
  logic [31:0] rdata_ff;
  logic [31:0] nxt_rdata;
  logic wr_acc;
  logic on_ff;
  logic nxt_on;
  logic pre_pend_ff;
  logic nxt_pre_pend;
  logic fix_pend_ff;
  logic nxt_fix_pend;
  logic [71:0] rpar_ff;
  logic [71:0] nxt_rpar;
  logic [71:0] wpar_ff;
  logic [71:0] nxt_wpar;
  logic [1:0] code_ff;
  logic [1:0] nxt_code;
  logic [IRQ_W-1:0] irq_st_ff;
  logic [IRQ_W-1:0] nxt_irq_st;
  logic [IRQ_W-1:0] irq_en_ff;
  logic [IRQ_W-1:0] nxt_irq_en;
  logic [IRQ_W-1:0] irq_clr;
  logic [IRQ_W-1:0] events;
  logic irq_ff;
  logic nxt_irq;
  seq_state_t state_ff;
  seq_state_t nxt_state;
  logic [9:0] cnt_ff;
  logic [9:0] nxt_cnt;
  logic tx_ready_ff;
  logic hold_ff;
  logic [7:0] rx_data_ff;
  logic [7:0] nxt_rx_data;
  logic rx_valid_ff;
  logic nxt_rx_valid;
  logic pre_accept;
  logic fix_accept;
  logic pre_done;
  logic fix_done;
  logic pop;

  // Byte-lane merge of a write into a held word
  function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++)
    begin
      if (be[i])
        res[i*8 +: 8] = wd[i*8 +: 8];
    end
    return res;
  endfunction : be_merge

  // Word-aligned address match
  function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
    return addr[7:2] == off[7:2];
  endfunction : hit

  // Reset release through two flops; assertion stays asynchronous
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rst_sync1_ff <= 1'b0;
      rst_sync2_ff <= 1'b0;
    end
    else
    begin
      rst_sync1_ff <= 1'b1;
      rst_sync2_ff <= rst_sync1_ff;
    end
  end
  assign srst_n = rst_sync2_ff;

  rs_ecc_engine u_engine (
    .clk(clk),
    .rst_n(srst_n),
    .ce(ce),
    .eif(eif.eng)
  );

  // Bus slave: one wait cycle per access; the write lands when waitrequest is low
  assign wr_acc = avs_write && !wait_ff;
  always_comb
  begin
    nxt_wait = !((avs_read || avs_write) && wait_ff);
    nxt_rdata = rdata_ff;
    if (avs_read && wait_ff)
    begin
      case (1'b1)
        hit(avs_address, OFF_CTRL): nxt_rdata = {29'h0, pre_pend_ff, fix_pend_ff, on_ff};
        hit(avs_address, OFF_RPAR1): nxt_rdata = rpar_ff[31:0];
        hit(avs_address, OFF_RPAR2): nxt_rdata = rpar_ff[63:32];
        hit(avs_address, OFF_RPAR3): nxt_rdata = {24'h0, rpar_ff[71:64]};
        hit(avs_address, OFF_WPAR1): nxt_rdata = wpar_ff[31:0];
        hit(avs_address, OFF_WPAR2): nxt_rdata = wpar_ff[63:32];
        hit(avs_address, OFF_WPAR3): nxt_rdata = {24'h0, wpar_ff[71:64]};
        hit(avs_address, OFF_STAT): nxt_rdata = {30'h0, code_ff};
        hit(avs_address, OFF_IRQ_ST): nxt_rdata = {29'h0, irq_st_ff};
        hit(avs_address, OFF_IRQ_EN): nxt_rdata = {29'h0, irq_en_ff};
        default: nxt_rdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge clk or negedge srst_n)
  begin
    if (!srst_n)
    begin
      wait_ff <= 1'b1;
      rdata_ff <= 32'h0;
    end
    else if (ce)
    begin
      wait_ff <= nxt_wait;
      rdata_ff <= nxt_rdata;
    end
  end

  // Software-visible registers; a hardware set beats a same-cycle clear
  assign events = {dec_done && on_ff, fix_done, pre_done};
  assign irq_clr = (wr_acc && hit(avs_address, OFF_IRQ_CLR) && avs_byteenable[0]) ? avs_writedata[IRQ_W-1:0] : 3'h0;
  always_comb
  begin
    nxt_on = on_ff;
    nxt_pre_pend = pre_pend_ff;
    nxt_fix_pend = fix_pend_ff;
    nxt_rpar = rpar_ff;
    nxt_wpar = wpar_ff;
    nxt_code = code_ff;
    nxt_irq_en = irq_en_ff;
    if (pre_accept || !on_ff)
      nxt_pre_pend = 1'b0;
    if (fix_accept || !on_ff)
      nxt_fix_pend = 1'b0;
    if (wr_acc && hit(avs_address, OFF_CTRL) && avs_byteenable[0])
    begin
      nxt_on = avs_writedata[BIT_ENGINE_ON];
      // Zero in a kick bit leaves any pending kick alone
      if (avs_writedata[BIT_PRECOMP_KICK] && avs_writedata[BIT_ENGINE_ON])
        nxt_pre_pend = 1'b1;
      if (avs_writedata[BIT_RELOAD_KICK] && avs_writedata[BIT_ENGINE_ON])
        nxt_fix_pend = 1'b1;
    end
    if (wr_acc && hit(avs_address, OFF_RPAR1))
      nxt_rpar[31:0] = be_merge(rpar_ff[31:0], avs_writedata, avs_byteenable);
    if (wr_acc && hit(avs_address, OFF_RPAR2))
      nxt_rpar[63:32] = be_merge(rpar_ff[63:32], avs_writedata, avs_byteenable);
    if (wr_acc && hit(avs_address, OFF_RPAR3) && avs_byteenable[0])
      nxt_rpar[71:64] = avs_writedata[7:0];
    if (wr_acc && hit(avs_address, OFF_IRQ_EN) && avs_byteenable[0])
      nxt_irq_en = avs_writedata[IRQ_W-1:0];
    if (pre_done)
      nxt_wpar = eif.parity;
    if (dec_done && on_ff)
      nxt_code = dec_code;
    nxt_irq_st = (irq_st_ff & ~irq_clr) | events;
    nxt_irq = |(nxt_irq_st & nxt_irq_en);
  end

  always_ff @(posedge clk or negedge srst_n)
  begin
    if (!srst_n)
    begin
      on_ff <= RST_ENGINE_ON;
      pre_pend_ff <= 1'b0;
      fix_pend_ff <= 1'b0;
      rpar_ff <= RST_PARITY;
      wpar_ff <= RST_PARITY;
      code_ff <= RST_ERR_CODE;
      irq_st_ff <= 3'h0;
      irq_en_ff <= 3'h0;
      irq_ff <= 1'b0;
    end
    else if (ce)
    begin
      on_ff <= nxt_on;
      pre_pend_ff <= nxt_pre_pend;
      fix_pend_ff <= nxt_fix_pend;
      rpar_ff <= nxt_rpar;
      wpar_ff <= nxt_wpar;
      code_ff <= nxt_code;
      irq_st_ff <= nxt_irq_st;
      irq_en_ff <= nxt_irq_en;
      irq_ff <= nxt_irq;
    end
  end

  // Kick sequencer; precompute wins if both kicks are pending together
  assign pop = (state_ff == SEQ_PRECOMP) && tx_valid && tx_ready_ff;
  always_comb
  begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    nxt_rx_data = rx_data_ff;
    nxt_rx_valid = rx_valid_ff;
    pre_accept = 1'b0;
    fix_accept = 1'b0;
    pre_done = 1'b0;
    fix_done = 1'b0;
    case (state_ff)
      SEQ_IDLE:
      begin
        nxt_cnt = 10'h000;
        if (pre_pend_ff && on_ff)
        begin
          pre_accept = 1'b1;
          nxt_state = SEQ_PRECOMP;
        end
        else if (fix_pend_ff && on_ff)
        begin
          fix_accept = 1'b1;
          nxt_state = SEQ_RELOAD;
        end
      end
      SEQ_PRECOMP:
      begin
        if (pop)
        begin
          nxt_cnt = cnt_ff + 10'h001;
          if (cnt_ff == BLOCK_LAST)
            nxt_state = SEQ_LATCH;
        end
      end
      SEQ_LATCH:
      begin
        pre_done = 1'b1;
        nxt_state = SEQ_IDLE;
      end
      SEQ_RELOAD:
      begin
        if (!rx_valid_ff || rx_ready)
        begin
          if (cnt_ff != BLOCK_END)
          begin
            nxt_rx_data = eif.rd_byte;
            nxt_rx_valid = 1'b1;
            nxt_cnt = cnt_ff + 10'h001;
          end
          else
          begin
            nxt_rx_valid = 1'b0;
            fix_done = 1'b1;
            nxt_state = SEQ_IDLE;
          end
        end
      end
      default: nxt_state = SEQ_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge srst_n)
  begin
    if (!srst_n)
    begin
      state_ff <= SEQ_IDLE;
      cnt_ff <= 10'h000;
      tx_ready_ff <= 1'b0;
      hold_ff <= 1'b0;
      rx_data_ff <= 8'h00;
      rx_valid_ff <= 1'b0;
    end
    else if (ce)
    begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      // Ready drops on the last byte so a 513th byte is never taken
      tx_ready_ff <= (nxt_state == SEQ_PRECOMP);
      hold_ff <= (nxt_state == SEQ_PRECOMP) || (nxt_state == SEQ_LATCH);
      rx_data_ff <= nxt_rx_data;
      rx_valid_ff <= nxt_rx_valid;
    end
  end

  // Engine hookup: encoder fed from the transmit FIFO, buffer fed by the read path
  assign eif.enc_clear = pre_accept;
  assign eif.enc_shift = pop;
  assign eif.enc_byte = tx_data;
  assign eif.cap_valid = rd_valid && on_ff;
  assign eif.cap_byte = rd_data;
  assign eif.cap_restart = dec_done;
  assign eif.fix_valid = fix_valid && on_ff;
  assign eif.fix_addr = fix_addr;
  assign eif.fix_xor = fix_xor;
  assign eif.rd_idx = cnt_ff[8:0];

  // Outputs straight from flops
  assign avs_readdata = rdata_ff;
  assign avs_waitrequest = wait_ff;
  assign tx_ready = tx_ready_ff;
  assign flash_tx_hold = hold_ff;
  assign read_parity = rpar_ff;
  assign reed_solomon_engine_on = on_ff;
  assign rx_data = rx_data_ff;
  assign rx_valid = rx_valid_ff;
  assign irq = irq_ff;
endmodule : nand_rs_ecc_ctrl
`default_nettype wire

// file: rs_ecc_asserts.sv
// Port-level concurrent checks for the Reed-Solomon ECC control block
`default_nettype none
module rs_ecc_asserts
  import rs_ecc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic tx_valid,
  input wire logic tx_ready,
  input wire logic flash_tx_hold,
  input wire logic [7:0] rx_data,
  input wire logic rx_valid,
  input wire logic rx_ready,
  input wire logic reed_solomon_engine_on
);
  logic [9:0] pop_ff;
  logic [9:0] nxt_pop;
  logic [9:0] beat_ff;
  logic [9:0] nxt_beat;

  // Pops per pass and beats per reload; a pass holds its value until the hold drops
  always_comb
  begin
    nxt_pop = flash_tx_hold ? pop_ff + 10'(tx_valid && tx_ready) : 10'h000;
    nxt_beat = rx_valid ? beat_ff + 10'(rx_ready) : 10'h000;
  end

  // Counter registers
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pop_ff <= 10'h000;
      beat_ff <= 10'h000;
    end
    else if (ce)
    begin
      pop_ff <= nxt_pop;
      beat_ff <= nxt_beat;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // Bus answers one cycle after a request, and only for one cycle
  a_wait_answer: assert property ((avs_read || avs_write) && avs_waitrequest && ce |=> !avs_waitrequest)
    else $error("bus request not answered next cycle");
  a_wait_pulse: assert property (!avs_waitrequest && ce |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  a_hold_while_pop: assert property (tx_ready |-> flash_tx_hold)
    else $error("transmit pop without flash hold");
  a_pop_bound: assert property (tx_valid && tx_ready |-> pop_ff < 10'h200)
    else $error("more than one block popped in a pass");
  a_pass_length: assert property ($fell(flash_tx_hold) |-> pop_ff == 10'h200)
    else $error("pass ended without a full block");
  a_engine_bit: assert property (avs_write && !avs_waitrequest && ce && avs_address == OFF_CTRL
    |=> reed_solomon_engine_on == $past(avs_writedata[0]))
    else $error("engine enable does not follow control write");
  a_ctrl_reserved: assert property (avs_read && !avs_waitrequest && avs_address == OFF_CTRL
    |-> avs_readdata[31:3] == 29'h0)
    else $error("control reserved bits not zero");
  a_rx_stall: assert property (rx_valid && !rx_ready |=> rx_valid && $stable(rx_data))
    else $error("reload byte changed while stalled");
  a_rx_bound: assert property (rx_valid && rx_ready |-> beat_ff < 10'h200)
    else $error("more than one block reloaded");
endmodule : rs_ecc_asserts

bind nand_rs_ecc_ctrl rs_ecc_asserts chk_u (.clk, .rst_n, .ce, .avs_address, .avs_read, .avs_write,
  .avs_writedata, .avs_readdata, .avs_waitrequest, .tx_valid, .tx_ready, .flash_tx_hold, .rx_data,
  .rx_valid, .rx_ready, .reed_solomon_engine_on);
`default_nettype wire

// file: tb.sv
// Self-checking bench for the Reed-Solomon ECC control block
`default_nettype none
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin n_mismatch++; \
  $display("MISMATCH t=%0t got=%0h exp=%0h", $time, (a), (e)); end end
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import rs_ecc_pkg::*;
  typedef struct packed {logic we; logic [7:0] a; logic [31:0] d;} row_t;
  logic clk = 1'b0, rst_n = 1'b0, ce = 1'b1, avs_read = 1'b0, avs_write = 1'b0;
  logic tx_valid = 1'b0, rd_valid = 1'b0, dec_done = 1'b0, fix_valid = 1'b0, rx_ready = 1'b0;
  logic tx_en = 1'b0, rx_en = 1'b0, hold_bad = 1'b0;
  logic [7:0] avs_address = 8'h00, tx_data = 8'h00, rd_data = 8'h00, fix_xor = 8'h00, expb;
  logic [31:0] avs_writedata = 32'h0, q, avs_readdata;
  logic [3:0] avs_byteenable = 4'hf;
  logic [1:0] dec_code = 2'h0;
  logic [8:0] fix_addr = 9'h000;
  logic avs_waitrequest, tx_ready, flash_tx_hold, reed_solomon_engine_on, rx_valid, irq;
  logic [71:0] read_parity;
  logic [71:0] exp_par;
  logic [7:0] rx_data;
  int n_mismatch = 0, tests_run = 0, cyc = 0, i, cnt;
  // Reads carry their expected value in d
  row_t rows [15] = '{'{1'b0, OFF_CTRL, 32'h0}, '{1'b1, OFF_RPAR1, 32'ha5a51234}, '{1'b0, OFF_RPAR1, 32'ha5a51234},
    '{1'b1, OFF_RPAR3, 32'hffffffff}, '{1'b0, OFF_RPAR3, 32'hff}, '{1'b1, OFF_WPAR1, 32'hdeadbeef},
    '{1'b0, OFF_WPAR1, 32'h0}, '{1'b1, 8'h00, 32'h5}, '{1'b0, 8'h00, 32'h0}, '{1'b0, 8'hfc, 32'h0},
    '{1'b1, OFF_IRQ_EN, 32'h7}, '{1'b0, OFF_IRQ_EN, 32'h7}, '{1'b1, OFF_CTRL, 32'h4},
    '{1'b0, OFF_CTRL, 32'h0}, '{1'b1, OFF_CTRL, 32'h1}};

  nand_rs_ecc_ctrl dut_u (.clk, .rst_n, .ce, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .tx_data, .tx_valid, .tx_ready, .flash_tx_hold,
    .rd_data, .rd_valid, .dec_done, .dec_code, .fix_valid, .fix_addr, .fix_xor, .read_parity,
    .reed_solomon_engine_on, .rx_data, .rx_valid, .rx_ready, .irq);

  // Clock source
  initial forever #4 clk = ~clk;

  // Transmit source advances per pop; both streams stall now and then to exercise holding
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (tx_valid && tx_ready)
      tx_data <= tx_data + 8'h01;
    tx_valid <= tx_en && (cyc % 3 != 0);
    rx_ready <= rx_en && (cyc % 2 != 0);
  end

  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : tally_and_finish

  // One Avalon access; waitrequest is read at the rising edge, before the flops move,
  // so the write lands and read data is taken at the very edge the request is released
  task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d, output logic [31:0] rd);
    int k;
    @(posedge clk);
    avs_address <= a;
    avs_write <= we;
    avs_read <= !we;
    avs_writedata <= d;
    k = 0;
    do
    begin
      @(posedge clk);
      k++;
    end
    while (avs_waitrequest !== 1'b0 && k < 20);
    if (avs_waitrequest !== 1'b0)
    begin
      n_mismatch++;
      tally_and_finish();
    end
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus

  // Reference field multiply in Horner form, kept apart from the design's own routine
  function automatic logic [7:0] ref_mul(input logic [7:0] a, input logic [7:0] b);
    logic [7:0] p;
    p = 8'h00;
    for (int k = 7; k >= 0; k--)
    begin
      p = {p[6:0], 1'b0} ^ (p[7] ? GF_POLY : 8'h00);
      if (b[k])
        p = p ^ a;
    end
    return p;
  endfunction : ref_mul

  // Expected parity of one pass over bytes 0, 1, 2 ... (modulo 256) divided by the generator
  function automatic logic [71:0] ref_parity();
    logic [7:0] r [0:8];
    logic [7:0] f;
    logic [71:0] res;
    res = 72'h0;
    for (int k = 0; k < PARITY_BYTES; k++)
      r[k] = 8'h00;
    for (int n = 0; n < BLOCK_BYTES; n++)
    begin
      f = n[7:0] ^ r[8];
      for (int k = PARITY_BYTES - 1; k > 0; k--)
        r[k] = r[k-1] ^ ref_mul(f, RS_GEN_COEF[k]);
      r[0] = ref_mul(f, RS_GEN_COEF[0]);
    end
    for (int k = 0; k < PARITY_BYTES; k++)
      res[k*8 +: 8] = r[k];
    return res;
  endfunction : ref_parity

  // One precompute pass with the transmit stream running, then all nine parity bytes read back
  task automatic precompute_pass();
    logic [71:0] par;
    par = 72'h0;
    tx_en <= 1'b1;
    bus(1'b1, OFF_CTRL, 32'h5, q);
    cnt = 0;
    for (i = 0; i < 4000 && !(cnt == 512 && !flash_tx_hold); i++)
    begin
      @(negedge clk);
      if (tx_valid && tx_ready)
        cnt++;
      if (tx_ready && !flash_tx_hold)
        hold_bad = 1'b1;
    end
    if (i >= 4000)
    begin
      n_mismatch++;
      tally_and_finish();
    end
    @(posedge clk);
    tx_en <= 1'b0;
    `CHK(cnt, 512)
    `CHK(hold_bad, 1'b0)
    bus(1'b0, OFF_CTRL, 32'h0, q);
    `CHK(q, 32'h1)
    bus(1'b0, OFF_WPAR1, 32'h0, q);
    par[31:0] = q;
    bus(1'b0, OFF_WPAR2, 32'h0, q);
    par[63:32] = q;
    bus(1'b0, OFF_WPAR3, 32'h0, q);
    `CHK(q[31:8], 24'h0)
    par[71:64] = q[7:0];
    `CHK(par, exp_par)
  endtask : precompute_pass

  // Main sequence: register table, then precompute, error codes, read capture and reload
  initial
  begin
    exp_par = ref_parity();
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    foreach (rows[r])
    begin
      bus(rows[r].we, rows[r].a, rows[r].d, q);
      if (!rows[r].we)
        `CHK(q, rows[r].d)
    end
    `CHK(read_parity, 72'hff_00000000_a5a51234)
    precompute_pass();
    bus(1'b0, OFF_IRQ_ST, 32'h0, q);
    `CHK(q[IRQ_PRECOMP_DONE], 1'b1)
    `CHK(irq, 1'b1)
    bus(1'b1, OFF_IRQ_CLR, 32'h7, q);
    bus(1'b0, OFF_IRQ_ST, 32'h0, q);
    `CHK(q, 32'h0)
    `CHK(irq, 1'b0)
    // The same 512 bytes pushed again must give the same parity, so the encoder restarts clean
    precompute_pass();
    // Every result code in turn
    for (int c = 0; c < 4; c++)
    begin
      @(posedge clk);
      dec_code <= c[1:0];
      dec_done <= 1'b1;
      @(posedge clk);
      dec_done <= 1'b0;
      bus(1'b0, OFF_STAT, 32'h0, q);
      `CHK(q, {30'h0, c[1:0]})
    end
    for (int b = 0; b < 512; b++)
    begin
      @(posedge clk);
      rd_valid <= 1'b1;
      rd_data <= b[7:0] ^ 8'h3c;
    end
    @(posedge clk);
    rd_valid <= 1'b0;
    fix_valid <= 1'b1;
    fix_addr <= 9'h005;
    fix_xor <= 8'hff;
    @(posedge clk);
    fix_valid <= 1'b0;
    dec_code <= 2'h1;
    dec_done <= 1'b1;
    @(posedge clk);
    dec_done <= 1'b0;
    bus(1'b0, OFF_STAT, 32'h0, q);
    `CHK(q, 32'h1)
    bus(1'b0, OFF_IRQ_ST, 32'h0, q);
    `CHK(q[IRQ_READ_DONE], 1'b1)
    // Reload the corrected block with the receive side stalling
    rx_en <= 1'b1;
    bus(1'b1, OFF_CTRL, 32'h3, q);
    cnt = 0;
    for (i = 0; i < 4000 && cnt < 512; i++)
    begin
      @(negedge clk);
      if (rx_valid && rx_ready)
      begin
        expb = cnt[7:0] ^ 8'h3c ^ ((cnt == 5) ? 8'hff : 8'h00);
        `CHK(rx_data, expb)
        cnt++;
      end
    end
    if (i >= 4000)
    begin
      n_mismatch++;
      tally_and_finish();
    end
    `CHK(cnt, 512)
    repeat (3) @(negedge clk);
    `CHK(rx_valid, 1'b0)
    bus(1'b0, OFF_IRQ_ST, 32'h0, q);
    `CHK(q[IRQ_RELOAD_DONE], 1'b1)
    bus(1'b0, OFF_CTRL, 32'h0, q);
    `CHK(q, 32'h1)
    // Clock enable low freezes state: a block result offered then is not taken
    @(posedge clk);
    ce <= 1'b0;
    dec_code <= 2'h2;
    dec_done <= 1'b1;
    @(posedge clk);
    ce <= 1'b1;
    dec_done <= 1'b0;
    bus(1'b0, OFF_STAT, 32'h0, q);
    `CHK(q, 32'h1)
    // Mid-run reset: state drops at once, and the bus answers again after the release
    @(posedge clk);
    rst_n <= 1'b0;
    @(posedge clk);
    `CHK(reed_solomon_engine_on, RST_ENGINE_ON)
    `CHK(avs_waitrequest, 1'b1)
    `CHK(irq, 1'b0)
    `CHK(read_parity, RST_PARITY)
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    bus(1'b0, OFF_CTRL, 32'h0, q);
    `CHK(q, 32'h0)
    tally_and_finish();
  end
endmodule : tb
`default_nettype wire
